// *** src/eipsl_pkg.sv ***
// Package for the external interrupt flag and pin-switch block.
// Assumes an AXI4-Lite slave with 32-bit data and word-aligned registers.
// Functional notes
// - Word access forces address bits one and zero low.
// - Condition word saved per byte lane; read back whole.
// - Ext4/ext3 flag set by select toggle, pin low, matching sense.
// - Ext1 flag set likewise from its own register.
// - Ext0 flag set likewise from a third register.
// - Wakeup flag set when its select rises with pin low, falling edge selected.
// - Combined input senses chosen source; a switch can form an edge.
// - Rising sense, source 1 to 0, pin low, pwm high: flag set.
// - Clear right after a select write is ignored.
// - Flag write clears zero bits, keeps one bits.
// - Wakeup flag set by selected edge; cleared by writing zero.
// - Wakeup edge select per pin: zero falling (reset), one rising.
// - Combined field picks rising, falling or both edges.
// - Enables gate flags; wakeup group shares one enable.
package eipsl_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_PIN_SEL_A = 8'h00; // ext4 bit4, ext3 bit3
    localparam logic [7:0] OFS_PIN_SEL_B = 8'h04; // ext1 bit1
    localparam logic [7:0] OFS_PIN_SEL_C = 8'h08; // ext0 bit0
    localparam logic [7:0] OFS_WAKE_SEL = 8'h0C;
    localparam logic [7:0] OFS_EDGE_SENSE = 8'h10;
    localparam logic [7:0] OFS_CMB_EDGE = 8'h14; // [1:0] field, [2] source select
    localparam logic [7:0] OFS_WAKE_EDGE = 8'h18;
    localparam logic [7:0] OFS_IRQ_EN = 8'h1C; // [4,3,2,1,0] irq, [5] wakeup group
    localparam logic [7:0] OFS_IRQ_FLAGS = 8'h20; // [4,3,2,1,0]
    localparam logic [7:0] OFS_WAKE_FLAGS = 8'h24;
    localparam logic [7:0] OFS_CCR_SAVE = 8'h28; // word save/restore of condition codes
    localparam logic [7:0] OFS_REQ = 8'h2C; // read-only gated requests
    localparam int BIT_EXT0 = 0;
    localparam int BIT_EXT1 = 1;
    localparam int BIT_CMB = 2;
    localparam int BIT_EXT3 = 3;
    localparam int BIT_EXT4 = 4;
    localparam int BIT_WAKE_EN = 5;
    localparam int BIT_CMB_SRC = 2;
    localparam logic [1:0] CMB_FALL = 2'h0;
    localparam logic [1:0] CMB_RISE = 2'h1;
    localparam logic [1:0] CMB_BOTH = 2'h2;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int HOLDOFF_ACC = 1; // bus accesses after a select write that clear nothing
endpackage

// *** src/eipsl_edge_det.sv ***
// Edge detector with select gating for one interrupt input.
// Assumes the pin level is synchronous to core_clk.
module eipsl_edge_det (
    input wire logic core_clk, // System clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic pin_lvl, // Pin level
    input wire logic sel, // Function selected
    input wire logic rise_en, // Detect rising edges
    input wire logic fall_en, // Detect falling edges
    output logic hit // Matching edge this cycle
);
    logic seen_q;
    logic seen_d;

    // Deselected input reads high, so switching can itself form an edge
    assign seen_d = sel ? pin_lvl : 1'b1;

    // Previous effective level, idle high
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            seen_q <= 1'b1;
        end else begin
            seen_q <= seen_d;
        end
    end

    assign hit = (rise_en & ~seen_q & seen_d) | (fall_en & seen_q & ~seen_d);
endmodule

// *** src/eipsl_top.sv ***
// External interrupt flag logic with pin-function switching effects.
// Assumes AXI4-Lite master, synchronous pin inputs and one clock domain.
module eipsl_top #(
    parameter int N_WAKE = 8 // Wakeup pins
) (
    input wire logic core_clk, // System clock, 40 MHz
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic [eipsl_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [eipsl_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read valid
    input wire logic s_axi_rready, // Read ready
    input wire logic ext4_pin_n, // External interrupt 4 pin
    input wire logic ext3_pin_n, // External interrupt 3 pin
    input wire logic ext1_pin_n, // External interrupt 1 pin
    input wire logic ext0_pin_n, // External interrupt 0 pin
    input wire logic combined_irq_pin, // Combined interrupt pin
    input wire logic internal_pwm_irq_source, // Internal PWM output
    input wire logic [N_WAKE-1:0] wakeup_pin_n, // Wakeup pins
    output logic [4:0] irq_req, // Gated requests {4,3,cmb,1,0}
    output logic wakeup_req // Gated wakeup group request
);
    import eipsl_pkg::*;

    initial begin
        if (N_WAKE < 1 || N_WAKE > 8) begin
            $error("N_WAKE must be 1 to 8");
        end
    end

    // Register state
    logic [7:0] pin_select_reg_a_q;
    logic [7:0] pin_select_reg_b_q;
    logic [7:0] pin_select_reg_c_q;
    logic [7:0] wakeup_select_reg_q;
    logic [7:0] edge_sense_reg_q;
    logic [7:0] combined_edge_select_reg_q;
    logic [7:0] wakeup_edge_reg_q;
    logic [7:0] irq_enable_reg_q;
    logic [4:0] irq_request_flags_q;
    logic [N_WAKE-1:0] wakeup_request_flags_q;
    logic [15:0] ccr_save_q;
    logic [1:0] holdoff_q;

    // Write and read channel state
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;

    // Register map decode, shared by read and write paths
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] w;
        w = {a[ADDR_W-1:2], 2'b00};
        case (w)
            OFS_PIN_SEL_A, OFS_PIN_SEL_B, OFS_PIN_SEL_C, OFS_WAKE_SEL,
            OFS_EDGE_SENSE, OFS_CMB_EDGE, OFS_WAKE_EDGE, OFS_IRQ_EN,
            OFS_IRQ_FLAGS, OFS_WAKE_FLAGS, OFS_CCR_SAVE, OFS_REQ: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // Write handshake: address and data taken in either order
    logic wr_go;
    logic [ADDR_W-1:0] wr_addr;
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign wr_go = (aw_held_q || (s_axi_awvalid && s_axi_awready))
                && (w_held_q || (s_axi_wvalid && s_axi_wready)) && !bvalid_q;
    assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;

    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [ADDR_W-1:0] wr_word;
    logic lane0_wr;
    assign wr_data = w_held_q ? wdata_q : s_axi_wdata;
    assign wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
    assign wr_word = {wr_addr[ADDR_W-1:2], 2'b00};
    assign lane0_wr = wr_go && wr_strb[0];

    // Holding the halves of a split write
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else if (wr_go) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    // Write response
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // A select write blocks flag clears in the next bus access, however late it comes
    logic sel_wr;
    assign sel_wr = lane0_wr && (wr_word == OFS_PIN_SEL_A || wr_word == OFS_PIN_SEL_B
                 || wr_word == OFS_PIN_SEL_C || wr_word == OFS_WAKE_SEL
                 || wr_word == OFS_CMB_EDGE);
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            holdoff_q <= 2'h0;
        end else if (sel_wr) begin
            holdoff_q <= 2'(HOLDOFF_ACC);
        end else if ((wr_go || (s_axi_arvalid && !rvalid_q)) && holdoff_q != 2'h0) begin
            holdoff_q <= holdoff_q - 2'h1;
        end
    end

    // Configuration registers, low byte lane only
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pin_select_reg_a_q <= RST_BYTE;
            pin_select_reg_b_q <= RST_BYTE;
            pin_select_reg_c_q <= RST_BYTE;
            wakeup_select_reg_q <= RST_BYTE;
            edge_sense_reg_q <= RST_BYTE;
            combined_edge_select_reg_q <= RST_BYTE;
            wakeup_edge_reg_q <= RST_BYTE;
            irq_enable_reg_q <= RST_BYTE;
        end else if (lane0_wr) begin
            case (wr_word)
                OFS_PIN_SEL_A: pin_select_reg_a_q <= wr_data[7:0];
                OFS_PIN_SEL_B: pin_select_reg_b_q <= wr_data[7:0];
                OFS_PIN_SEL_C: pin_select_reg_c_q <= wr_data[7:0];
                OFS_WAKE_SEL: wakeup_select_reg_q <= wr_data[7:0];
                OFS_EDGE_SENSE: edge_sense_reg_q <= wr_data[7:0];
                OFS_CMB_EDGE: combined_edge_select_reg_q <= wr_data[7:0];
                OFS_WAKE_EDGE: wakeup_edge_reg_q <= wr_data[7:0];
                OFS_IRQ_EN: irq_enable_reg_q <= wr_data[7:0];
                default: ;
            endcase
        end
    end

    // Condition word: saved per byte lane, read back whole
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ccr_save_q <= 16'h0000;
        end else if (wr_go && wr_word == OFS_CCR_SAVE) begin
            if (wr_strb[0]) begin
                ccr_save_q[7:0] <= wr_data[7:0];
            end
            if (wr_strb[1]) begin
                ccr_save_q[15:8] <= wr_data[15:8];
            end
        end
    end

    // Edge detectors: ext4, ext3, ext1, ext0 share one structure
    logic [4:0] irq_hit;
    logic [3:0] ext_pin;
    logic [3:0] ext_sel;
    logic [3:0] ext_sense;
    assign ext_pin = {ext4_pin_n, ext3_pin_n, ext1_pin_n, ext0_pin_n};
    assign ext_sel = {pin_select_reg_a_q[BIT_EXT4], pin_select_reg_a_q[BIT_EXT3],
                      pin_select_reg_b_q[BIT_EXT1],
                      pin_select_reg_c_q[BIT_EXT0]};
    assign ext_sense = {edge_sense_reg_q[BIT_EXT4], edge_sense_reg_q[BIT_EXT3],
                        edge_sense_reg_q[BIT_EXT1], edge_sense_reg_q[BIT_EXT0]};

    logic [3:0] ext_hit;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ext
            eipsl_edge_det u_det (
                .core_clk(core_clk),
                .reset_n(reset_n),
                .pin_lvl(ext_pin[gi]),
                .sel(ext_sel[gi]),
                .rise_en(ext_sense[gi]),
                .fall_en(~ext_sense[gi]),
                .hit(ext_hit[gi])
            );
        end
    endgenerate

    // Combined source; sense counts on the inverted level, so high pwm to low pin is rising
    logic cmb_lvl;
    logic cmb_hit;
    logic [1:0] cmb_field;
    assign cmb_lvl = combined_edge_select_reg_q[BIT_CMB_SRC] ? internal_pwm_irq_source
                   : combined_irq_pin;
    assign cmb_field = combined_edge_select_reg_q[1:0];
    eipsl_edge_det u_cmb (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pin_lvl(cmb_lvl),
        .sel(1'b1),
        .rise_en(cmb_field == CMB_FALL || cmb_field == CMB_BOTH),
        .fall_en(cmb_field == CMB_RISE || cmb_field == CMB_BOTH),
        .hit(cmb_hit)
    );
    assign irq_hit = {ext_hit[3], ext_hit[2], cmb_hit, ext_hit[1], ext_hit[0]};

    // Wakeup detectors, per-pin edge select
    logic [N_WAKE-1:0] wake_hit;
    generate
        for (gi = 0; gi < N_WAKE; gi++) begin : g_wake
            eipsl_edge_det u_det (
                .core_clk(core_clk),
                .reset_n(reset_n),
                .pin_lvl(wakeup_pin_n[gi]),
                .sel(wakeup_select_reg_q[gi]),
                .rise_en(wakeup_edge_reg_q[gi]),
                .fall_en(~wakeup_edge_reg_q[gi]),
                .hit(wake_hit[gi])
            );
        end
    endgenerate

    // Flag clear masks; write-zero clears, blocked during holdoff
    logic clr_ok;
    logic [4:0] irq_clr;
    logic [N_WAKE-1:0] wake_clr;
    assign clr_ok = lane0_wr && holdoff_q == 2'h0;
    assign irq_clr = (clr_ok && wr_word == OFS_IRQ_FLAGS) ? ~wr_data[4:0] : 5'h00;
    assign wake_clr = (clr_ok && wr_word == OFS_WAKE_FLAGS)
                    ? ~wr_data[N_WAKE-1:0] : '0;

    // Flags: set outranks a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            irq_request_flags_q <= 5'h00;
            wakeup_request_flags_q <= '0;
        end else begin
            irq_request_flags_q <= (irq_request_flags_q & ~irq_clr) | irq_hit;
            wakeup_request_flags_q <= (wakeup_request_flags_q & ~wake_clr) | wake_hit;
        end
    end

    // Enabled requests
    assign irq_req = irq_request_flags_q & irq_enable_reg_q[4:0];
    assign wakeup_req = (|wakeup_request_flags_q) & irq_enable_reg_q[BIT_WAKE_EN];

    // Read channel; one-cycle latency, unmapped reads zero with error
    assign s_axi_arready = !rvalid_q;
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
                OFS_PIN_SEL_A: rdata_q <= {24'h0, pin_select_reg_a_q};
                OFS_PIN_SEL_B: rdata_q <= {24'h0, pin_select_reg_b_q};
                OFS_PIN_SEL_C: rdata_q <= {24'h0, pin_select_reg_c_q};
                OFS_WAKE_SEL: rdata_q <= {24'h0, wakeup_select_reg_q};
                OFS_EDGE_SENSE: rdata_q <= {24'h0, edge_sense_reg_q};
                OFS_CMB_EDGE: rdata_q <= {24'h0, combined_edge_select_reg_q};
                OFS_WAKE_EDGE: rdata_q <= {24'h0, wakeup_edge_reg_q};
                OFS_IRQ_EN: rdata_q <= {24'h0, irq_enable_reg_q};
                OFS_IRQ_FLAGS: rdata_q <= {27'h0, irq_request_flags_q};
                OFS_WAKE_FLAGS: rdata_q <= 32'(wakeup_request_flags_q);
                OFS_CCR_SAVE: rdata_q <= {16'h0, ccr_save_q};
                OFS_REQ: rdata_q <= {26'h0, wakeup_req, irq_req};
                default: rdata_q <= 32'h0;
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
endmodule

// *** testbench/eipsl_pin_model.sv ***
// Far-side model: interrupt pin levels and the internal PWM output.
// Assumes levels are sampled on core_clk and move only after a rising edge.
module eipsl_pin_model (
    input wire logic core_clk, // System clock
    output logic [3:0] ext_pin_n, // Levels {ext4,ext3,ext1,ext0}
    output logic cmb_pin, // Combined interrupt pin
    output logic pwm_out, // Internal PWM output
    output logic [7:0] wake_pin_n // Wakeup pins
);
    // Pins idle high, so no pin select switch can fake an edge before the bench asks; pwm idles low
    initial begin
        ext_pin_n = 4'hF;
        cmb_pin = 1'b1;
        pwm_out = 1'b0;
        wake_pin_n = 8'hFF;
    end

    // New levels land just after an edge; a few cycles let detectors settle
    task automatic drive(input logic [3:0] e, input logic c, input logic p, input logic [7:0] w);
        @(posedge core_clk);
        ext_pin_n <= e;
        cmb_pin <= c;
        pwm_out <= p;
        wake_pin_n <= w;
        repeat (4) @(posedge core_clk);
    endtask
endmodule

// *** testbench/eipsl_assertions.sv ***
// Checker of the flag block, watching only the top module ports.
// Assumes the master offers write address and write data together.
module eipsl_assertions #(
    parameter int N_WAKE = 8 // Wakeup pins
) (
    input wire logic core_clk, // Clock
    input wire logic reset_n, // Reset
    input wire logic [eipsl_pkg::ADDR_W-1:0] s_axi_awaddr, // Addr
    input wire logic s_axi_awvalid, // Valid
    input wire logic s_axi_awready, // Ready
    input wire logic [31:0] s_axi_wdata, // Data
    input wire logic [3:0] s_axi_wstrb, // Lanes
    input wire logic s_axi_wvalid, // Valid
    input wire logic s_axi_wready, // Ready
    input wire logic s_axi_bvalid, // Resp
    input wire logic s_axi_arvalid, // Valid
    input wire logic s_axi_arready, // Ready
    input wire logic s_axi_rvalid, // Resp
    input wire logic ext4_pin_n, // Pin
    input wire logic ext3_pin_n, // Pin
    input wire logic ext1_pin_n, // Pin
    input wire logic ext0_pin_n, // Pin
    input wire logic combined_irq_pin, // Pin
    input wire logic internal_pwm_irq_source, // PWM
    input wire logic [N_WAKE-1:0] wakeup_pin_n, // Pins
    input wire logic [4:0] irq_req, // Requests
    input wire logic wakeup_req // Request
);
    import eipsl_pkg::*;
    logic [5:0] en_q;
    logic [2:0] quiet_q;
    logic wr_go;
    assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // Enable shadow follows the executing write
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            en_q <= 6'h00;
        end else if (wr_go && s_axi_wstrb[0] && s_axi_awaddr[7:2] == OFS_IRQ_EN[7:2]) begin
            en_q <= s_axi_wdata[5:0];
        end
    end

    // Saturating count of calm cycles; a new flag needs some recent cause
    always_ff @(posedge core_clk) begin
        if (!reset_n || wr_go || $changed({ext4_pin_n, ext3_pin_n, ext1_pin_n, ext0_pin_n,
                combined_irq_pin, internal_pwm_irq_source, wakeup_pin_n})) begin
            quiet_q <= 3'h0;
        end else if (quiet_q != 3'h7) begin
            quiet_q <= quiet_q + 3'h1;
        end
    end

    sequence flag_wr_s;
        wr_go && s_axi_wstrb[0] && s_axi_awaddr[7:2] == OFS_IRQ_FLAGS[7:2];
    endsequence
    sequence wake_ones_s;
        wr_go && s_axi_wstrb[0] && s_axi_awaddr[7:2] == OFS_WAKE_FLAGS[7:2]
            && s_axi_wdata[N_WAKE-1:0] == {N_WAKE{1'b1}};
    endsequence

    irq_gate_a: assert property ((irq_req & ~en_q[4:0]) == 5'h00)
        else $error("req while disabled");
    wake_gate_a: assert property (!en_q[BIT_WAKE_EN] |-> !wakeup_req)
        else $error("wake req while disabled");
    flag_keep_a: assert property (flag_wr_s |=>
        (($past(irq_req) & $past(s_axi_wdata[4:0])) & ~irq_req) == 5'h00)
        else $error("flag lost under a one bit");
    flag_clear_a: assert property (flag_wr_s ##0 quiet_q == 3'h7 |=>
        (irq_req & ~$past(s_axi_wdata[4:0])) == 5'h00)
        else $error("flag not cleared");
    wake_keep_a: assert property (wake_ones_s ##0 wakeup_req |=> wakeup_req)
        else $error("wake flags lost");
    fresh_flag_a: assert property (((irq_req & ~$past(irq_req)) != 5'h00)
        || $rose(wakeup_req) |-> quiet_q < 3'h4)
        else $error("req with no cause");
    write_resp_a: assert property (wr_go |=> s_axi_bvalid)
        else $error("no write response");
    read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read response");
endmodule

bind eipsl_top eipsl_assertions #(.N_WAKE(N_WAKE)) eipsl_assertions_i (
    .core_clk(core_clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .ext4_pin_n(ext4_pin_n), .ext3_pin_n(ext3_pin_n), .ext1_pin_n(ext1_pin_n),
    .ext0_pin_n(ext0_pin_n), .combined_irq_pin(combined_irq_pin),
    .internal_pwm_irq_source(internal_pwm_irq_source), .wakeup_pin_n(wakeup_pin_n),
    .irq_req(irq_req), .wakeup_req(wakeup_req));

// *** testbench/eipsl_top_bench.sv ***
// Self-checking bench of the flag block, driven over AXI4-Lite.
// Assumes the pin model as far side and a bound port checker.
module eipsl_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import eipsl_pkg::*;
    logic core_clk, reset_n, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, cmb_pin, pwm_out, wake_req;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, ext_n;
    logic [1:0] bresp, rresp;
    logic [7:0] wake_n;
    logic [4:0] irq;
    logic [7:0] sel_ofs [4];
    int sel_bit [4];
    int n_fail, n_tests;

    eipsl_top eipsl_top_i (.core_clk(core_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext4_pin_n(ext_n[3]), .ext3_pin_n(ext_n[2]), .ext1_pin_n(ext_n[1]),
        .ext0_pin_n(ext_n[0]), .combined_irq_pin(cmb_pin), .internal_pwm_irq_source(pwm_out),
        .wakeup_pin_n(wake_n), .irq_req(irq), .wakeup_req(wake_req));
    eipsl_pin_model eipsl_pin_model_i (.core_clk(core_clk), .ext_pin_n(ext_n),
        .cmb_pin(cmb_pin), .pwm_out(pwm_out), .wake_pin_n(wake_n));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic stop_test();
        if (n_fail == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", w, exp, seen);
        end
    endtask

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'h1);
        logic ad = 1'b0;
        logic wd = 1'b0;
        int k;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 60; k++) begin
            @(posedge core_clk);
            if (ad && wd && bvalid) break;
            ad = ad || awready;
            wd = wd || wready;
            awvalid <= !ad;
            wvalid <= !wd;
        end
        bready <= 1'b0;
        if (k == 60) begin
            n_fail++;
            stop_test();
        end
        check("bresp", 32'(bresp), 32'(RESP_OKAY));
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
        logic ad = 1'b0;
        int k;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 60; k++) begin
            @(posedge core_clk);
            if (ad && rvalid) break;
            ad = ad || arready;
            arvalid <= !ad;
        end
        v = rdata;
        e = rresp;
        rready <= 1'b0;
        if (k == 60) begin
            n_fail++;
            stop_test();
        end
    endtask

    task automatic expect_reg(input logic [7:0] a, input logic [31:0] e, input string w);
        logic [31:0] v;
        logic [1:0] s;
        rd(a, v, s);
        check(w, v, e);
    endtask

    // Ext pins stay low after the first step; only the other levels move
    task automatic pins(input logic c, input logic p, input logic [7:0] w);
        eipsl_pin_model_i.drive(4'h0, c, p, w);
    endtask

    // Main sequence; every flag clear but the early-clear check follows a read after the last switch
    initial begin
        int i;
        logic [7:0] m;
        logic [31:0] d;
        logic [1:0] r;
        {reset_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = '0;
        sel_ofs = '{OFS_PIN_SEL_A, OFS_PIN_SEL_A, OFS_PIN_SEL_B, OFS_PIN_SEL_C};
        sel_bit = '{BIT_EXT4, BIT_EXT3, BIT_EXT1, BIT_EXT0};
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        for (i = 0; i < 12; i++) expect_reg(8'(i * 4), 32'h0, "reset");
        rd(8'h30, d, r);
        check("bad resp", 32'(r), 32'(RESP_SLVERR));
        check("bad data", d, 32'h0);
        wr(8'h11, 32'h1B);
        expect_reg(OFS_EDGE_SENSE, 32'h1B, "odd addr");
        wr(OFS_EDGE_SENSE, 32'h0);
        wr(OFS_CCR_SAVE, 32'h2B5A, 4'h3);
        expect_reg(OFS_CCR_SAVE, 32'h2B5A, "ccr word");
        wr(OFS_IRQ_EN, 32'h3F);
        pins(1'b1, 1'b0, 8'hFF);
        expect_reg(OFS_IRQ_FLAGS, 32'h0, "idle fall");
        for (i = 0; i < 4; i++) begin
            m = 8'h01 << sel_bit[i];
            wr(sel_ofs[i], 32'(m));
            expect_reg(OFS_IRQ_FLAGS, 32'(m), "sel fall");
            check("irq_req", 32'(irq), 32'(m));
            wr(sel_ofs[i], 32'h0);
            expect_reg(OFS_IRQ_FLAGS, 32'(m), "desel fall");
            wr(OFS_IRQ_FLAGS, 32'(~m));
            wr(OFS_EDGE_SENSE, 32'(m));
            wr(sel_ofs[i], 32'(m));
            expect_reg(OFS_IRQ_FLAGS, 32'h0, "sel rise");
            wr(sel_ofs[i], 32'h0);
            expect_reg(OFS_IRQ_FLAGS, 32'(m), "desel rise");
            wr(OFS_IRQ_FLAGS, 32'h0);
            wr(OFS_EDGE_SENSE, 32'h0);
        end
        wr(OFS_PIN_SEL_B, 32'h2);
        wr(OFS_PIN_SEL_C, 32'h1);
        wr(OFS_IRQ_FLAGS, 32'h0);
        expect_reg(OFS_IRQ_FLAGS, 32'h3, "early clear");
        wr(OFS_IRQ_FLAGS, 32'hFD);
        expect_reg(OFS_IRQ_FLAGS, 32'h1, "clear bit one");
        wr(OFS_IRQ_EN, 32'h3E);
        check("irq_req masked", 32'(irq), 32'h0);
        wr(OFS_IRQ_EN, 32'h3F);
        wr(OFS_IRQ_FLAGS, 32'h0);
        wr(OFS_PIN_SEL_B, 32'h0);
        wr(OFS_PIN_SEL_C, 32'h0);
        pins(1'b1, 1'b0, 8'h5A);
        wr(OFS_WAKE_SEL, 32'hFF);
        expect_reg(OFS_WAKE_FLAGS, 32'hA5, "wake sel");
        check("wakeup_req", 32'(wake_req), 32'h1);
        wr(OFS_WAKE_FLAGS, 32'hFF);
        expect_reg(OFS_WAKE_FLAGS, 32'hA5, "wake ones");
        wr(OFS_IRQ_EN, 32'h1F);
        check("wakeup_req masked", 32'(wake_req), 32'h0);
        wr(OFS_WAKE_FLAGS, 32'h0);
        wr(OFS_WAKE_EDGE, 32'hFF);
        pins(1'b1, 1'b0, 8'hFF);
        expect_reg(OFS_WAKE_FLAGS, 32'hA5, "wake rise");
        wr(OFS_WAKE_FLAGS, 32'h0);
        pins(1'b1, 1'b0, 8'h00);
        expect_reg(OFS_WAKE_FLAGS, 32'h0, "wake fall off");
        wr(OFS_WAKE_EDGE, 32'h0);
        pins(1'b1, 1'b0, 8'hFF);
        pins(1'b1, 1'b0, 8'h00);
        expect_reg(OFS_WAKE_FLAGS, 32'hFF, "wake fall");
        wr(OFS_CMB_EDGE, 32'h1);
        pins(1'b0, 1'b1, 8'h00);
        expect_reg(OFS_IRQ_FLAGS, 32'h4, "pin fall, rise");
        wr(OFS_IRQ_FLAGS, 32'h0);
        wr(OFS_CMB_EDGE, 32'h5);
        expect_reg(OFS_IRQ_FLAGS, 32'h0, "to pwm high");
        wr(OFS_CMB_EDGE, 32'h1);
        expect_reg(OFS_IRQ_FLAGS, 32'h4, "to low pin");
        wr(OFS_IRQ_FLAGS, 32'h0);
        wr(OFS_CMB_EDGE, 32'h6);
        expect_reg(OFS_IRQ_FLAGS, 32'h4, "switch, both");
        wr(OFS_IRQ_FLAGS, 32'h0);
        pins(1'b0, 1'b0, 8'h00);
        expect_reg(OFS_IRQ_FLAGS, 32'h4, "pwm fall, both");
        wr(OFS_IRQ_FLAGS, 32'h0);
        wr(OFS_CMB_EDGE, 32'h4);
        pins(1'b0, 1'b1, 8'h00);
        expect_reg(OFS_IRQ_FLAGS, 32'h4, "pwm rise, fall");
        wr(OFS_IRQ_FLAGS, 32'h0);
        pins(1'b0, 1'b0, 8'h00);
        expect_reg(OFS_IRQ_FLAGS, 32'h0, "pwm fall, fall");
        stop_test();
    end
endmodule
